// File: rtl/ata_regs_pkg.sv
// Constants for the task-file register block
package ata_regs_pkg;
	localparam int PIN_W = 15;
	localparam logic [14:0] PIN_IDLE = 15'h7800;
	// Command block indexes (ctl block uses 6)
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_ERROR = 3'h1;
	localparam logic [2:0] IDX_COUNT = 3'h2;
	localparam logic [2:0] IDX_SECTOR = 3'h3;
	localparam logic [2:0] IDX_CYL_LO = 3'h4;
	localparam logic [2:0] IDX_CYL_HI = 3'h5;
	localparam logic [2:0] IDX_UNIT_HEAD = 3'h6;
	localparam logic [2:0] IDX_STATUS = 3'h7;
	localparam logic [2:0] IDX_ALT_STATUS = 3'h6;
	localparam int BIT_SOFT_RESET = 2;
	localparam int BIT_NIEN = 1;
	localparam int BIT_UNIT = 4;
	localparam logic [2:0] UH_FIXED = 3'h5;
	localparam logic [7:0] RST_ERROR = 8'h01;
	localparam logic [7:0] RST_COUNT = 8'h01;
	localparam logic [7:0] RST_SECTOR = 8'h01;
	localparam logic [7:0] RST_CYL = 8'h00;
	localparam logic [7:0] RST_UNIT_HEAD = 8'ha0;
	localparam logic [8:0] FULL_COUNT = 9'h100;
	localparam logic [7:0] CMD_READ = 8'h20;
	localparam logic [7:0] CMD_READ_NR = 8'h21;
	localparam logic [7:0] CMD_READ_LONG = 8'h22;
	localparam logic [7:0] CMD_WRITE = 8'h30;
	localparam logic [7:0] CMD_WRITE_NR = 8'h31;
	localparam logic [7:0] CMD_WRITE_LONG = 8'h32;
	localparam logic [7:0] CMD_VERIFY = 8'h40;
	localparam logic [7:0] CMD_VERIFY_NR = 8'h41;
	localparam logic [7:0] CMD_FORMAT = 8'h50;
	localparam logic [7:0] CMD_DIAG = 8'h90;
	localparam logic [7:0] CMD_INIT_PARAMS = 8'h91;
	localparam logic [7:0] CMD_READ_DMA = 8'hc8;
	localparam logic [7:0] CMD_READ_DMA_NR = 8'hc9;
	localparam logic [7:0] CMD_READ_BUF = 8'he4;
	localparam logic [7:0] CMD_WRITE_BUF = 8'he8;
	localparam logic [7:0] CMD_IDENTIFY = 8'hec;
	localparam logic [7:0] CMD_EXTENDED = 8'hf0;
	localparam logic [3:0] NIB_RECAL = 4'h1;
	localparam logic [3:0] NIB_SEEK = 4'h7;
	localparam int CLK_PERIOD_NS = 50;
	localparam int CLK_HZ = 20_000_000;
	localparam int BUSY_SET_NS = 400;
	localparam int BUSY_SET_CYC = BUSY_SET_NS / CLK_PERIOD_NS;
	localparam int WR_BUSY_NS = 5000;
	localparam int WR_BUSY_CYC = WR_BUSY_NS / CLK_PERIOD_NS;
	localparam int RESET_BUSY_S = 30;
	localparam int RESET_BUSY_CYC = RESET_BUSY_S * CLK_HZ;
	typedef enum logic [2:0] {
		CLS_OTHER, CLS_READ, CLS_WRITE, CLS_DMA_READ, CLS_GEOMETRY,
		CLS_EXTENDED, CLS_DIAG
	} cmd_class_e;
endpackage

// File: rtl/ata_task_file_registers.sv
// Task-file command block registers with status, busy and lockout
`timescale 1ns/10ps
`default_nettype none
module ata_task_file_registers #(
	parameter int unsigned RESET_BUSY_MAX = ata_regs_pkg::RESET_BUSY_CYC
) (
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic                     command_block_select_n_i,
	input  wire logic                     control_block_select_n_i,
	input  wire logic [2:0]               da_i,
	input  wire logic                     rd_n_i,
	input  wire logic                     wr_n_i,
	input  wire logic [7:0]               dd_i,
	output logic [7:0]                    dd_o,
	output logic                          dd_oe_n_o,
	output logic                          irq_o,
	input  wire logic                     unit_id_i,
	input  wire logic                     sector_done_i,
	input  wire logic                     cmd_done_i,
	input  wire logic                     cmd_error_i,
	input  wire logic [7:0]               err_code_i,
	input  wire logic                     intr_req_i,
	input  wire logic                     buf_filled_i,
	input  wire logic                     release_i,
	input  wire logic                     ready_live_i,
	input  wire logic                     write_fault_live_i,
	input  wire logic                     settle_live_i,
	input  wire logic                     transfer_request_i,
	input  wire logic                     corrected_i,
	input  wire logic                     index_i,
	output logic                          cmd_start_o,
	output logic [7:0]                    cmd_code_o,
	output ata_regs_pkg::cmd_class_e      cmd_class_o,
	output logic [7:0]                    count_param_o,
	output logic [8:0]                    count_total_o,
	output logic [7:0]                    sector_param_o,
	output logic [15:0]                   cylinder_param_o,
	output logic [3:0]                    head_number_bits_o,
	output logic                          unit_select_bit_o,
	output logic [7:0]                    feature_param_o,
	output logic                          busy_flag_o
);
	import ata_regs_pkg::*;

	localparam int RC_W = $clog2(RESET_BUSY_MAX + 1);

	function automatic logic busy_on_cmd(input logic [7:0] c);
		busy_on_cmd = (c[7:4] == NIB_RECAL) | (c[7:4] == NIB_SEEK)
			| (c == CMD_READ) | (c == CMD_READ_NR)
			| (c == CMD_READ_LONG) | (c == CMD_VERIFY)
			| (c == CMD_VERIFY_NR) | (c == CMD_INIT_PARAMS)
			| (c == CMD_DIAG) | (c == CMD_IDENTIFY)
			| (c == CMD_READ_BUF);
	endfunction

	function automatic cmd_class_e class_of(input logic [7:0] c);
		case (c)
			CMD_READ, CMD_READ_NR, CMD_READ_LONG: class_of = CLS_READ;
			CMD_WRITE, CMD_WRITE_NR, CMD_WRITE_LONG,
			CMD_WRITE_BUF: class_of = CLS_WRITE;
			CMD_READ_DMA, CMD_READ_DMA_NR: class_of = CLS_DMA_READ;
			CMD_INIT_PARAMS, CMD_FORMAT: class_of = CLS_GEOMETRY;
			CMD_EXTENDED: class_of = CLS_EXTENDED;
			CMD_DIAG: class_of = CLS_DIAG;
			default: class_of = CLS_OTHER;
		endcase
	endfunction

	// Pin synchroniser; a bit changes once stages 2 and 3 agree
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_f;
	wire  [PIN_W-1:0] pin_raw = {command_block_select_n_i,
		control_block_select_n_i, rd_n_i, wr_n_i, da_i, dd_i};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			pin_s3 <= PIN_IDLE;
			pin_f  <= PIN_IDLE;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));
		end
	end

	wire       cmd_sel = ~pin_f[14];
	wire       ctl_sel = ~pin_f[13];
	wire       rd_n_f  = pin_f[12];
	wire       wr_n_f  = pin_f[11];
	wire [2:0] da_f    = pin_f[10:8];

	// Address and data caught while the write strobe is low, used at
	// its rising edge so late skew between pins cannot corrupt them
	logic       rd_n_d;
	logic       wr_n_d;
	logic [12:0] wr_lat;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_n_d <= 1'b1;
			wr_n_d <= 1'b1;
			wr_lat <= '0;
		end else begin
			rd_n_d <= rd_n_f;
			wr_n_d <= wr_n_f;
			if (!wr_n_f)
				wr_lat <= {cmd_sel, ctl_sel, pin_f[10:0]};
		end
	end

	wire       rd_fall = rd_n_d & ~rd_n_f;
	wire       wr_rise = ~wr_n_d & wr_n_f;
	wire [2:0] wr_da   = wr_lat[10:8];
	wire [7:0] wr_dd   = wr_lat[7:0];

	logic       busy_flag;
	logic       soft_reset_bit;
	logic       int_disable;
	logic       unit_id;
	logic       strap_taken;
	logic [7:0] count_param;
	logic [7:0] sector_param;
	logic [7:0] cyl_lo;
	logic [7:0] cyl_hi;
	logic [4:0] unit_head;
	logic [7:0] feature_param;
	logic [7:0] error_reg;

	wire selected = unit_head[BIT_UNIT] == unit_id;
	wire blk_wr = wr_rise & wr_lat[12] & ~wr_lat[11];
	wire ctl_wr = wr_rise & wr_lat[11] & ~wr_lat[12]
		& (wr_da == IDX_ALT_STATUS);
	wire reg_wr = blk_wr & ~busy_flag;
	wire cmd_wr = reg_wr & (wr_da == IDX_STATUS);
	wire cmd_accept = cmd_wr & (selected | (wr_dd == CMD_DIAG));
	wire blk_rd = rd_fall & cmd_sel & ~ctl_sel & selected;
	wire status_rd = blk_rd & (da_f == IDX_STATUS);
	wire alt_rd = rd_fall & ctl_sel & ~cmd_sel & selected
		& (da_f == IDX_ALT_STATUS);
	wire err_done = cmd_done_i & cmd_error_i;

	// Strap level caught once, after reset release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap_taken <= 1'b0;
			unit_id     <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			unit_id     <= unit_id_i;
		end
	end

	// Device control: soft reset and interrupt disable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			soft_reset_bit <= 1'b0;
			int_disable    <= 1'b0;
		end else if (ctl_wr) begin
			soft_reset_bit <= wr_dd[BIT_SOFT_RESET];
			int_disable    <= wr_dd[BIT_NIEN];
		end
	end

	// Parameter registers; controller updates win over host writes
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_param   <= RST_COUNT;
			sector_param  <= RST_SECTOR;
			cyl_lo        <= RST_CYL;
			cyl_hi        <= RST_CYL;
			unit_head     <= RST_UNIT_HEAD[4:0];
			feature_param <= '0;
			error_reg     <= RST_ERROR;
		end else if (soft_reset_bit) begin
			count_param   <= RST_COUNT;
			sector_param  <= RST_SECTOR;
			cyl_lo        <= RST_CYL;
			cyl_hi        <= RST_CYL;
			unit_head     <= RST_UNIT_HEAD[4:0];
			error_reg     <= RST_ERROR;
		end else begin
			if (reg_wr && wr_da == IDX_COUNT)
				count_param <= wr_dd;
			if (reg_wr && wr_da == IDX_SECTOR)
				sector_param <= wr_dd;
			if (reg_wr && wr_da == IDX_CYL_LO)
				cyl_lo <= wr_dd;
			if (reg_wr && wr_da == IDX_CYL_HI)
				cyl_hi <= wr_dd;
			if (reg_wr && wr_da == IDX_UNIT_HEAD)
				unit_head <= wr_dd[4:0];
			if (reg_wr && wr_da == IDX_ERROR)
				feature_param <= wr_dd;
			if (sector_done_i) begin
				count_param  <= count_param - 8'h01;
				sector_param <= sector_param + 8'h01;
			end
			if (err_done)
				error_reg <= err_code_i;
		end
	end

	// Busy: reset phase bounded by a cycle counter
	logic            rst_phase;
	logic [RC_W-1:0] rst_cnt;
	logic            next_busy;
	wire rst_timeout = rst_phase & busy_flag & ~soft_reset_bit
		& (rst_cnt == RC_W'(RESET_BUSY_MAX - 1));
	wire busy_set = soft_reset_bit
		| (cmd_accept & busy_on_cmd(wr_dd))
		| buf_filled_i;
	wire busy_clr = cmd_done_i | release_i | rst_timeout;

	always_comb begin
		next_busy = busy_flag;
		if (busy_clr)
			next_busy = 1'b0;
		if (busy_set)
			next_busy = 1'b1;
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			busy_flag <= 1'b1;
			rst_phase <= 1'b1;
			rst_cnt   <= '0;
		end else begin
			busy_flag <= next_busy;
			rst_phase <= soft_reset_bit | (rst_phase & next_busy);
			if (soft_reset_bit || !rst_phase)
				rst_cnt <= '0;
			else
				rst_cnt <= rst_cnt + 1'b1;
		end
	end

	// Status flags; an event in the clearing cycle wins
	logic       err_flag;
	logic       fixed_data_flag;
	logic       rotation_mark_flag;
	logic       frozen;
	logic [2:0] held;
	logic       irq_pend;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			err_flag           <= 1'b0;
			fixed_data_flag    <= 1'b0;
			rotation_mark_flag <= 1'b0;
			frozen             <= 1'b0;
			held               <= '0;
			irq_pend           <= 1'b0;
		end else begin
			rotation_mark_flag <= index_i;
			if (cmd_accept)
				err_flag <= 1'b0;
			if (err_done)
				err_flag <= 1'b1;
			if (cmd_accept)
				fixed_data_flag <= 1'b0;
			if (corrected_i)
				fixed_data_flag <= 1'b1;
			if (!frozen)
				held <= {ready_live_i, write_fault_live_i, settle_live_i};
			if (status_rd)
				frozen <= 1'b0;
			if (err_done)
				frozen <= 1'b1;
			if (status_rd || soft_reset_bit)
				irq_pend <= 1'b0;
			if (cmd_done_i || intr_req_i)
				irq_pend <= 1'b1;
		end
	end

	wire [2:0] live3 = {ready_live_i, write_fault_live_i, settle_live_i};
	wire [2:0] shown = frozen ? held : live3;
	wire [7:0] status_word = {busy_flag, shown, transfer_request_i,
		fixed_data_flag, rotation_mark_flag, err_flag};
	wire [7:0] uh_word = {UH_FIXED, unit_head};

	logic [7:0] reg_word;
	always_comb begin
		case (da_f)
			IDX_ERROR:     reg_word = error_reg;
			IDX_COUNT:     reg_word = count_param;
			IDX_SECTOR:    reg_word = sector_param;
			IDX_CYL_LO:    reg_word = cyl_lo;
			IDX_CYL_HI:    reg_word = cyl_hi;
			IDX_UNIT_HEAD: reg_word = uh_word;
			IDX_STATUS:    reg_word = status_word;
			default:       reg_word = '0;
		endcase
	end

	// Read data held in a flop; pin driven until the strobe rises
	wire [7:0] rd_word = (busy_flag || alt_rd) ? status_word : reg_word;
	logic drive_q;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			dd_o    <= '0;
			drive_q <= 1'b0;
		end else begin
			if (blk_rd || alt_rd)
				dd_o <= rd_word;
			if (rd_n_f)
				drive_q <= 1'b0;
			else if (blk_rd || alt_rd)
				drive_q <= 1'b1;
		end
	end

	assign dd_oe_n_o = ~drive_q;
	assign irq_o = irq_pend & ~int_disable & selected;

	// Command hand-off to the controller
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmd_start_o <= 1'b0;
			cmd_code_o  <= '0;
			cmd_class_o <= CLS_OTHER;
		end else begin
			cmd_start_o <= cmd_accept;
			if (cmd_accept) begin
				cmd_code_o  <= wr_dd;
				cmd_class_o <= class_of(wr_dd);
			end
		end
	end

	assign count_param_o = count_param;
	assign count_total_o = (count_param == 8'h00) ? FULL_COUNT
		: {1'b0, count_param};
	assign sector_param_o = sector_param;
	assign cylinder_param_o = {cyl_hi, cyl_lo};
	assign head_number_bits_o = unit_head[3:0];
	assign unit_select_bit_o = unit_head[BIT_UNIT];
	assign feature_param_o = feature_param;
	assign busy_flag_o = busy_flag;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	localparam int BSC = BUSY_SET_CYC;
	localparam int WBC = WR_BUSY_CYC;

	property p_zero_count;
		count_param == 8'h00 |-> count_total_o == FULL_COUNT;
	endproperty
	a_zero_count: assert property (p_zero_count)
		else $error("zero count not 256");
	property p_sector_step;
		sector_done_i && !soft_reset_bit |=> count_param
			== $past(count_param) - 8'h01
			&& sector_param == $past(sector_param) + 8'h01;
	endproperty
	a_sector_step: assert property (p_sector_step)
		else $error("sector step wrong");
	property p_irq_ack;
		status_rd && !cmd_done_i && !intr_req_i |=> !irq_pend;
	endproperty
	a_irq_ack: assert property (p_irq_ack)
		else $error("status read left irq");
	property p_alt_keep;
		alt_rd && !status_rd && !soft_reset_bit |=> irq_pend
			== $past(irq_pend) || $past(cmd_done_i | intr_req_i);
	endproperty
	a_alt_keep: assert property (p_alt_keep)
		else $error("alt read changed irq");
	property p_cmd_busy;
		cmd_accept && busy_on_cmd(wr_dd) |-> ##[1:BSC] busy_flag;
	endproperty
	a_cmd_busy: assert property (p_cmd_busy)
		else $error("busy late after command");
	property p_buf_busy;
		buf_filled_i |-> ##[1:WBC] busy_flag;
	endproperty
	a_buf_busy: assert property (p_buf_busy)
		else $error("busy late after buffer");
	property p_lockout;
		blk_wr && busy_flag && !sector_done_i && !soft_reset_bit
			|=> $stable(cyl_lo) && $stable(cyl_hi) && $stable(unit_head);
	endproperty
	a_lockout: assert property (p_lockout)
		else $error("write while busy took effect");
	property p_busy_read;
		blk_rd && busy_flag |=> dd_o == $past(status_word);
	endproperty
	a_busy_read: assert property (p_busy_read)
		else $error("busy read not status");
	property p_uh_fixed;
		blk_rd && !busy_flag && da_f == IDX_UNIT_HEAD
			|=> dd_o[7:5] == UH_FIXED;
	endproperty
	a_uh_fixed: assert property (p_uh_fixed)
		else $error("unit/head fixed bits wrong");
	property p_freeze;
		frozen && !status_rd |=> frozen && $stable(held);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("frozen flags moved");
	property p_err_flag;
		err_done |=> err_flag && status_word[0];
	endproperty
	a_err_flag: assert property (p_err_flag)
		else $error("error flag not set");
	property p_rst_bound;
		rst_phase && !soft_reset_bit |-> rst_cnt < RC_W'(RESET_BUSY_MAX);
	endproperty
	a_rst_bound: assert property (p_rst_bound)
		else $error("reset busy too long");

	c_cmd_read: cover property (cmd_accept && busy_on_cmd(wr_dd));
	c_status_ack: cover property (irq_pend ##1 status_rd);
	c_err_freeze: cover property (err_done ##[1:200] status_rd);
	c_diag_other: cover property (cmd_accept && !selected);
endmodule
`default_nettype wire

// File: sim/host_pio_model.sv
// Host adapter model issuing programmed register cycles
`timescale 1ns/10ps
`default_nettype none
module host_pio_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	input  wire logic       rdata_oe_n_i,
	output logic            cmd_sel_n_o,
	output logic            ctl_sel_n_o,
	output logic [2:0]      da_o,
	output logic            rd_n_o,
	output logic            wr_n_o,
	output logic [7:0]      wdata_o
);
	// Strobes must outlast the three-flop pin filter
	localparam int HOLD = 6;
	initial begin
		cmd_sel_n_o = 1'b1;
		ctl_sel_n_o = 1'b1;
		da_o = 3'h0;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wdata_o = 8'h00;
	end
	task automatic select(input logic ctl, input logic [2:0] idx);
		@(posedge clk_i);
		cmd_sel_n_o <= ctl;
		ctl_sel_n_o <= ~ctl;
		da_o <= idx;
	endtask
	task automatic release_bus();
		@(posedge clk_i);
		cmd_sel_n_o <= 1'b1;
		ctl_sel_n_o <= 1'b1;
		// Released lines must not keep showing the last value
		da_o <= ~da_o;
		wdata_o <= ~wdata_o;
	endtask
	task automatic write(input logic ctl, input logic [2:0] idx,
			input logic [7:0] val);
		select(ctl, idx);
		wdata_o <= val;
		wr_n_o <= 1'b0;
		repeat (HOLD) @(posedge clk_i);
		wr_n_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		release_bus();
	endtask
	task automatic read(input logic ctl, input logic [2:0] idx,
			output logic [7:0] val);
		int n;
		select(ctl, idx);
		rd_n_o <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_i);
			n++;
		end while (rdata_oe_n_i !== 1'b0 && n < 20);
		val = (n < 20) ? rdata_i : 8'hxx;
		@(posedge clk_i);
		rd_n_o <= 1'b1;
		repeat (HOLD) @(posedge clk_i);
		release_bus();
	endtask
endmodule
`default_nettype wire

// File: sim/ata_task_file_registers_tb.sv
// Self-checking bench for the task-file register block
`timescale 1ns/10ps
`default_nettype none
module ata_task_file_registers_tb;
	import ata_regs_pkg::*;
	localparam int unsigned BUSY_MAX = 100;
	logic        clk_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [5:0]  ev = 6'h00;
	logic        cmd_error_i = 1'b0;
	logic [7:0]  err_code_i = 8'h00;
	logic        ready_live_i = 1'b1;
	logic        write_fault_live_i = 1'b0;
	logic        settle_live_i = 1'b1;
	logic        transfer_request_i = 1'b0;
	wire logic   cs1_n, cs3_n, rd_n, wr_n, oe_n, irq, busy, unit_sel, start;
	wire logic [2:0]  da;
	wire logic [7:0]  wdata, rdata, code, cnt, sec, feat;
	wire logic [8:0]  total;
	wire logic [15:0] cyl;
	wire logic [3:0]  head;
	cmd_class_e  cls;
	int          n_mismatch = 0;
	int          n_checks = 0;
	int          n_start = 0;
	logic [7:0]  lfsr = 8'h44;
	logic [7:0]  v;
	logic [7:0]  mreg [8];
	logic        m_rdy = 1'b1, m_wf = 1'b0, m_settle = 1'b1, m_mark = 1'b0;
	logic        m_xfer = 1'b0, m_fixed = 1'b0, m_err = 1'b0;
	logic [7:0]  codes [6] = '{CMD_READ, CMD_WRITE, CMD_INIT_PARAMS,
		CMD_DIAG, CMD_READ_DMA, CMD_EXTENDED};
	cmd_class_e  classes [6] = '{CLS_READ, CLS_WRITE, CLS_GEOMETRY,
		CLS_DIAG, CLS_DMA_READ, CLS_EXTENDED};
	int          busy_now [6] = '{1, 0, 1, 1, 2, 2};

	always #25 clk_i = ~clk_i;

	// Start pulses stand one cycle; counted mid-cycle
	always @(negedge clk_i)
		if (start === 1'b1)
			n_start <= n_start + 1;

	host_pio_model host (.clk_i(clk_i), .rdata_i(rdata), .rdata_oe_n_i(oe_n),
		.cmd_sel_n_o(cs1_n), .ctl_sel_n_o(cs3_n), .da_o(da), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .wdata_o(wdata));

	ata_task_file_registers #(.RESET_BUSY_MAX(BUSY_MAX)) dut (
		.clk_i(clk_i), .rstn_i(rstn_i), .command_block_select_n_i(cs1_n),
		.control_block_select_n_i(cs3_n), .da_i(da), .rd_n_i(rd_n),
		.wr_n_i(wr_n), .dd_i(wdata), .dd_o(rdata), .dd_oe_n_o(oe_n),
		.irq_o(irq), .unit_id_i(1'b0), .sector_done_i(ev[0]),
		.cmd_done_i(ev[1]), .cmd_error_i(cmd_error_i),
		.err_code_i(err_code_i), .intr_req_i(1'b0), .buf_filled_i(ev[2]),
		.release_i(ev[3]), .ready_live_i(ready_live_i),
		.write_fault_live_i(write_fault_live_i),
		.settle_live_i(settle_live_i),
		.transfer_request_i(transfer_request_i), .corrected_i(ev[4]),
		.index_i(ev[5]), .cmd_start_o(start), .cmd_code_o(code),
		.cmd_class_o(cls), .count_param_o(cnt), .count_total_o(total),
		.sector_param_o(sec), .cylinder_param_o(cyl),
		.head_number_bits_o(head), .unit_select_bit_o(unit_sel),
		.feature_param_o(feat), .busy_flag_o(busy));

	function automatic logic [7:0] step(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] status(input logic b);
		return {b, m_rdy, m_wf, m_settle, m_xfer, m_fixed, m_mark, m_err};
	endfunction
	task automatic check(input string what, input logic [15:0] exp,
			input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic pulse(input int b);
		@(posedge clk_i);
		ev[b] <= 1'b1;
		@(posedge clk_i);
		ev[b] <= 1'b0;
		@(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic wr(input logic [2:0] idx, input logic [7:0] val);
		host.write(1'b0, idx, val);
		@(negedge clk_i);
	endtask
	task automatic rd(input logic [2:0] idx, input string what,
			input logic [7:0] exp);
		host.read(1'b0, idx, v);
		@(negedge clk_i);
		check(what, {8'h00, exp}, {8'h00, v});
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		mreg = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h00};
		repeat (5) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		check("busy after reset", 16'h1, {15'h0, busy});
		rd(IDX_COUNT, "locked read", status(1'b1));
		wr(IDX_CYL_LO, 8'h5a); // Lockout drops this write
		pulse(3);
		check("busy released", 16'h0, {15'h0, busy});
		for (int i = 1; i < 7; i++) begin
			rd(3'(i), "reset value", mreg[i]);
		end
		wr(IDX_COUNT, 8'h00);
		check("total", 16'h0100, {7'h00, total});
		for (int i = 2; i < 7; i++) begin
			lfsr = step(lfsr);
			mreg[i] = (i == 6) ? ((lfsr & 8'h0f) | 8'ha0) : lfsr;
			wr(3'(i), (i == 6) ? (lfsr & 8'hef) : lfsr);
			rd(3'(i), "readback", mreg[i]);
		end
		check("total", (mreg[2] == 0) ? 16'h100 : mreg[2], total);
		check("cylinder", {mreg[5], mreg[4]}, cyl);
		check("head", mreg[6][3:0], head);
		check("unit", 16'h0, {15'h0, unit_sel});
		wr(IDX_ERROR, lfsr);
		check("feature", lfsr, feat);
		wr(IDX_COUNT, 8'h03);
		wr(IDX_STATUS, CMD_READ);
		check("busy on read", 16'h1, {15'h0, busy});
		@(posedge clk_i);
		transfer_request_i <= 1'b1;
		m_xfer = 1'b1;
		pulse(0);
		pulse(0);
		check("count", 16'h1, cnt);
		check("sector", mreg[3] + 8'h02, sec);
		pulse(4);
		m_fixed = 1'b1;
		@(posedge clk_i);
		cmd_error_i <= 1'b1;
		err_code_i <= lfsr;
		pulse(1);
		m_err = 1'b1;
		check("busy at end", 16'h0, {15'h0, busy});
		@(posedge clk_i);
		cmd_error_i <= 1'b0;
		ready_live_i <= 1'b0;
		write_fault_live_i <= 1'b1;
		settle_live_i <= 1'b0;
		rd(IDX_UNIT_HEAD, "unit head", mreg[6]);
		host.read(1'b1, IDX_ALT_STATUS, v);
		check("alt status", status(1'b0), v);
		check("irq kept", 16'h1, {15'h0, irq});
		rd(IDX_ERROR, "error register", lfsr);
		rd(IDX_STATUS, "frozen status", status(1'b0));
		check("irq cleared", 16'h0, {15'h0, irq});
		{m_rdy, m_wf, m_settle} = 3'h2;
		rd(IDX_STATUS, "live status", status(1'b0));
		@(posedge clk_i);
		ev[5] <= 1'b1;
		m_mark = 1'b1;
		rd(IDX_STATUS, "mark status", status(1'b0));
		@(posedge clk_i);
		ev[5] <= 1'b0;
		{ready_live_i, write_fault_live_i, settle_live_i} <= 3'h5;
		transfer_request_i <= 1'b0;
		{m_rdy, m_wf, m_settle, m_xfer, m_fixed, m_err, m_mark} = 7'h50;
		for (int i = 0; i < 6; i++) begin
			wr(IDX_STATUS, codes[i]);
			check("code", codes[i], code);
			check("class", classes[i], cls);
			if (busy_now[i] < 2)
				check("busy", busy_now[i], busy);
			if (classes[i] == CLS_WRITE) begin
				pulse(2);
				check("busy after sector", 16'h1, {15'h0, busy});
			end
			pulse(1);
			check("irq", 16'h1, {15'h0, irq});
			rd(IDX_STATUS, "done status", status(1'b0));
		end
		wr(IDX_UNIT_HEAD, 8'h10);
		wr(IDX_STATUS, CMD_READ);
		check("other unit", CMD_EXTENDED, code);
		wr(IDX_STATUS, CMD_DIAG);
		check("diag both", CMD_DIAG, code);
		check("starts", 16'h8, n_start[15:0]);
		pulse(1);
		host.write(1'b1, IDX_ALT_STATUS, 8'h0c);
		@(negedge clk_i);
		check("soft busy", 16'h1, {15'h0, busy});
		check("soft count", 16'h1, cnt);
		check("soft cyl", 16'h0, cyl);
		host.write(1'b1, IDX_ALT_STATUS, 8'h08);
		repeat (BUSY_MAX + 5) @(posedge clk_i);
		@(negedge clk_i);
		check("busy bound", 16'h0, {15'h0, busy});
		rd(IDX_UNIT_HEAD, "soft unit head", 8'ha0);
		give_verdict();
	end
endmodule
`default_nettype wire
